// ---- hdl/bpos_bridge_pwm.sv ----
// Bridge PWM output steering: period timer, duty compare, dead band,
// direction change and pin steering behind a Wishbone classic slave.
// Assumes clock_in is the oscillator; instruction cycles are one in four.
`timescale 1ns/1ps

// Behaviour
// - Low two mode bits pick active-low or active-high for outputs A/C and B/D.
// - Full bridge drives all four outputs, at most two of them active.
// - Forward: A held active, PWM on D.
// - Reverse: C held active, PWM on B.
// - Half bridge delays only inactive-to-active edges, never deassertion.
// - Eight-bit dead-band count in instruction cycles between A and B edges.
// - Direction bit takes effect at the next PWM cycle; current cycle finishes.
// - A and C switch early by 1, 4 or 16 oscillator periods per prescale.
// - B and D held inactive during the early switch interval.
// - No dead band in full bridge operation.
// - Output latches are correct once one full PWM cycle has run.
// - Period timer flag goes from 0 to 1 once every 1 to 16 completed periods, per postscale.
// - Two-bit configuration field decodes single, half, forward, reverse.
// - Half bridge: PWM on A, complement on B.
// - Period match clears timer, sets PWM unless duty zero, latches duty.
module bpos_bridge_pwm (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rstn_in,
  // Wishbone slave
  input  wire bpos_pkg::bpos_wb_req_t wb_req_in,
  output logic [31:0]                wb_dat_out,
  output logic                       wb_ack_out,
  // Bridge pins and period flag
  output bpos_pkg::bpos_pins_t       bridge_pins_out,
  output logic                       period_timer_flag_out
);

  // Last phase of one timer step for a prescale code
  function automatic logic [5:0] ph_last_f(input logic [1:0] ps);
    logic [5:0] r;
    r = bpos_pkg::PH_LAST_16;
    if (ps == 2'h0) begin
      r = bpos_pkg::PH_LAST_1;
    end else if (ps == 2'h1) begin
      r = bpos_pkg::PH_LAST_4;
    end
    return r;
  endfunction

  // First phase of the early switch for a prescale code
  function automatic logic [5:0] ph_lead_f(input logic [1:0] ps);
    logic [5:0] r;
    r = bpos_pkg::PH_LEAD_16;
    if (ps == 2'h0) begin
      r = bpos_pkg::PH_LEAD_1;
    end else if (ps == 2'h1) begin
      r = bpos_pkg::PH_LEAD_4;
    end
    return r;
  endfunction

  // Two fine duty bits below the timer count for a prescale code
  function automatic logic [1:0] sub_f(input logic [1:0] ps, input logic [5:0] ph);
    logic [1:0] r;
    r = ph[5:4];
    if (ps == 2'h0) begin
      r = ph[1:0];
    end else if (ps == 2'h1) begin
      r = ph[3:2];
    end
    return r;
  endfunction

  // Software registers
  logic [7:0] gctl;
  logic [7:0] pir;
  logic [7:0] tmr;
  logic [7:0] tctl;
  logic [7:0] duty_hi;
  logic [7:0] ctl;
  logic [7:0] tris;
  logic [7:0] pie;
  logic [7:0] pr;
  logic [7:0] dband;

  // Internal state
  logic [9:0] duty_act;
  logic [1:0] ic_cnt;
  logic [5:0] phase;
  logic [3:0] post_cnt;
  logic       pwm_hold;
  logic       pwm_q;
  logic       act_rev;
  logic [7:0] db_cnt;
  logic       wait_a;
  logic       wait_b;
  logic       a_on;
  logic       b_on;

  // Bus decode
  wire        bus_req  = wb_req_in.cyc & wb_req_in.stb;
  wire        bus_wr   = bus_req & wb_req_in.we & wb_ack_out & wb_req_in.sel[0];
  wire [7:0]  bus_idx  = wb_req_in.adr[9:2];
  wire [7:0]  wdat     = wb_req_in.dat[7:0];
  wire        wr_int   = bus_wr & (bus_idx == bpos_pkg::IDX_GLOBAL);
  wire        wr_pir   = bus_wr & (bus_idx == bpos_pkg::IDX_PIR);
  wire        wr_tmr   = bus_wr & (bus_idx == bpos_pkg::IDX_TMR);
  wire        wr_t2    = bus_wr & (bus_idx == bpos_pkg::IDX_TIMCTL);
  wire        wr_duty  = bus_wr & (bus_idx == bpos_pkg::IDX_DUTY);
  wire        wr_ctl   = bus_wr & (bus_idx == bpos_pkg::IDX_CTL);
  wire        wr_tris  = bus_wr & (bus_idx == bpos_pkg::IDX_TRIS);
  wire        wr_pie   = bus_wr & (bus_idx == bpos_pkg::IDX_PIE);
  wire        wr_pr    = bus_wr & (bus_idx == bpos_pkg::IDX_PR);
  wire        wr_dband = bus_wr & (bus_idx == bpos_pkg::IDX_DBAND);

  // Read selection; unmapped words read zero
  logic [7:0] rd_byte;
  always_comb begin
    case (bus_idx)
      bpos_pkg::IDX_GLOBAL:  rd_byte = gctl;
      bpos_pkg::IDX_PIR:     rd_byte = pir;
      bpos_pkg::IDX_TMR:     rd_byte = tmr;
      bpos_pkg::IDX_TIMCTL:  rd_byte = {1'b0, tctl[6:0]};
      bpos_pkg::IDX_DUTY:    rd_byte = duty_hi;
      bpos_pkg::IDX_ACTDUTY: rd_byte = duty_act[9:2];
      bpos_pkg::IDX_CTL:     rd_byte = ctl;
      bpos_pkg::IDX_TRIS:    rd_byte = tris;
      bpos_pkg::IDX_PIE:     rd_byte = pie;
      bpos_pkg::IDX_PR:      rd_byte = pr;
      bpos_pkg::IDX_DBAND:   rd_byte = dband;
      default:               rd_byte = 8'h00;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req & ~wb_ack_out;
      wb_dat_out <= (bus_req & ~wb_ack_out) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Mode decode
  bpos_pkg::bpos_mode_t mode;
  always_comb begin
    case ({ctl[bpos_pkg::CTL_DIR], ctl[bpos_pkg::CTL_FULL]})
      2'b00:   mode = bpos_pkg::BPOS_SINGLE;
      2'b10:   mode = bpos_pkg::BPOS_HALF;
      2'b01:   mode = bpos_pkg::BPOS_FULL_FWD;
      2'b11:   mode = bpos_pkg::BPOS_FULL_REV;
      default: mode = bpos_pkg::BPOS_SINGLE;
    endcase
  end

  // Timer and duty compare terms
  wire        pwm_en     = &ctl[bpos_pkg::CTL_PWM_HI -: 2];
  wire        run        = tctl[bpos_pkg::T2_RUN];
  wire [1:0]  ps         = tctl[1:0];
  wire        ic_en      = (ic_cnt == bpos_pkg::IC_LAST);
  wire        tick_end   = run & (phase == ph_last_f(ps));
  wire        at_limit   = (tmr == pr);
  wire        period_end = tick_end & at_limit;
  wire [9:0]  duty_buf   = {duty_hi, ctl[bpos_pkg::CTL_DCLO_HI -: 2]};
  wire [9:0]  fine       = {tmr, sub_f(ps, phase)};
  wire        pwm        = pwm_hold & (fine != duty_act);
  wire        post_hit   = (post_cnt == tctl[bpos_pkg::T2_POST_HI -: 4]);
  wire        flag_set   = period_end & post_hit;
  wire        is_half    = (mode == bpos_pkg::BPOS_HALF);
  wire        is_full    = ctl[bpos_pkg::CTL_FULL];
  wire        dir_new    = ctl[bpos_pkg::CTL_DIR];
  wire        early      = is_full & (dir_new != act_rev) & run & at_limit &
                           (phase >= ph_lead_f(ps));

  // Instruction cycle divider
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ic_cnt <= 2'h0;
    end else begin
      ic_cnt <= ic_cnt + 2'h1;
    end
  end

  // Prescaler phase within one timer step
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase <= 6'h00;
    end else if (!run || tick_end) begin
      phase <= 6'h00;
    end else begin
      phase <= phase + 6'h01;
    end
  end

  // Period timer count; a bus write takes priority
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tmr <= bpos_pkg::RST_ZERO;
    end else if (wr_tmr) begin
      tmr <= wdat;
    end else if (period_end) begin
      tmr <= 8'h00;
    end else if (tick_end) begin
      tmr <= tmr + 8'h01;
    end
  end

  // Active duty latch loads at each period restart
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      duty_act <= 10'h000;
    end else if (period_end) begin
      duty_act <= duty_buf;
    end
  end

  // Raw PWM: set at restart unless duty is zero, cleared at duty match
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pwm_hold <= 1'b0;
    end else if (!pwm_en) begin
      pwm_hold <= 1'b0;
    end else if (period_end) begin
      pwm_hold <= (duty_buf != 10'h000);
    end else if (fine == duty_act) begin
      pwm_hold <= 1'b0;
    end
  end

  // Postscaler counts period matches between flag settings
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      post_cnt <= 4'h0;
    end else if (period_end) begin
      post_cnt <= post_hit ? 4'h0 : post_cnt + 4'h1;
    end
  end

  // Direction in force; a change waits for the next cycle
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      act_rev <= 1'b0;
    end else if (period_end) begin
      act_rev <= dir_new;
    end
  end

  // Flag register: a hardware set wins over a software write
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pir <= bpos_pkg::RST_ZERO;
    end else begin
      pir <= wr_pir ? wdat : pir;
      if (flag_set) begin
        pir[bpos_pkg::PIR_PERIOD] <= 1'b1;
      end
    end
  end

  // Plain storage registers
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gctl    <= bpos_pkg::RST_ZERO;
      tctl    <= bpos_pkg::RST_ZERO;
      duty_hi <= bpos_pkg::RST_ZERO;
      ctl     <= bpos_pkg::RST_ZERO;
      tris    <= bpos_pkg::RST_TRIS;
      pie     <= bpos_pkg::RST_ZERO;
      pr      <= bpos_pkg::RST_PR;
      dband   <= bpos_pkg::RST_ZERO;
    end else begin
      gctl    <= wr_int ? wdat : gctl;
      tctl    <= wr_t2 ? {1'b0, wdat[6:0]} : tctl;
      duty_hi <= wr_duty ? wdat : duty_hi;
      ctl     <= wr_ctl ? wdat : ctl;
      tris    <= wr_tris ? wdat : tris;
      pie     <= wr_pie ? wdat : pie;
      pr      <= wr_pr ? wdat : pr;
      dband   <= wr_dband ? wdat : dband;
    end
  end

  // Half-bridge rise requests: A follows PWM, B its complement
  wire rise_a = is_half & pwm & ~pwm_q;
  wire rise_b = is_half & ~pwm & pwm_q;
  wire db_zero = (dband == 8'h00);
  wire db_done = ic_en & (db_cnt == 8'h01);

  // Dead-band down-counter, reloaded at every rise request
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pwm_q  <= 1'b0;
      db_cnt <= 8'h00;
    end else begin
      pwm_q <= pwm;
      if (rise_a || rise_b) begin
        db_cnt <= dband;
      end else if (ic_en && db_cnt != 8'h00) begin
        db_cnt <= db_cnt - 8'h01;
      end
    end
  end

  // Half-bridge A: rises after the delay, falls at once
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      a_on   <= 1'b0;
      wait_a <= 1'b0;
    end else if (!is_half || !pwm) begin
      a_on   <= 1'b0;
      wait_a <= 1'b0;
    end else if (rise_a) begin
      a_on   <= db_zero;
      wait_a <= ~db_zero;
    end else if (wait_a && db_done) begin
      a_on   <= 1'b1;
      wait_a <= 1'b0;
    end
  end

  // Half-bridge B: rises after the delay, falls at once
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      b_on   <= 1'b0;
      wait_b <= 1'b0;
    end else if (!is_half || pwm) begin
      b_on   <= 1'b0;
      wait_b <= 1'b0;
    end else if (rise_b) begin
      b_on   <= db_zero;
      wait_b <= ~db_zero;
    end else if (wait_b && db_done) begin
      b_on   <= 1'b1;
      wait_b <= 1'b0;
    end
  end

  // Full-bridge steering without dead band; early switch of A and C
  wire dir_now = early ? dir_new : act_rev;
  wire full_a  = ~dir_now;
  wire full_c  = dir_now;
  wire full_b  = ~early & act_rev & pwm;
  wire full_d  = ~early & ~act_rev & pwm;

  // Logical activity of A..D per configuration
  logic [3:0] active;
  always_comb begin
    case (mode)
      bpos_pkg::BPOS_SINGLE:   active = {3'b000, pwm};
      bpos_pkg::BPOS_HALF:     active = {2'b00, b_on, a_on};
      bpos_pkg::BPOS_FULL_FWD: active = {full_d, full_c, full_b, full_a};
      bpos_pkg::BPOS_FULL_REV: active = {full_d, full_c, full_b, full_a};
      default:                 active = 4'h0;
    endcase
  end

  // Polarity per pin: A and C share one bit, B and D the other
  wire [3:0] pol_low = {ctl[bpos_pkg::CTL_POL_BD], ctl[bpos_pkg::CTL_POL_AC],
                        ctl[bpos_pkg::CTL_POL_BD], ctl[bpos_pkg::CTL_POL_AC]};
  wire [3:0] tris_pins = {tris[bpos_pkg::TRIS_D], tris[bpos_pkg::TRIS_C],
                          tris[bpos_pkg::TRIS_B], tris[bpos_pkg::TRIS_A]};
  wire [3:0] next_lvl;
  wire [3:0] next_oe;

  // Pin level and enable; a disabled module leaves latches low
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign next_lvl[gi] = pwm_en & (active[gi] ^ pol_low[gi]);
      assign next_oe[gi]  = ~tris_pins[gi];
    end
  endgenerate

  // Registered pins and flag
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bridge_pins_out       <= '0;
      period_timer_flag_out <= 1'b0;
    end else begin
      bridge_pins_out.lvl   <= next_lvl;
      bridge_pins_out.oe    <= next_oe;
      period_timer_flag_out <= pir[bpos_pkg::PIR_PERIOD];
    end
  end

endmodule

// ---- hdl/bpos_pkg.sv ----
// Constants, field layout and carrier types of the bridge PWM output stage.
// Assumes a Wishbone host with 32-bit data; each register sits in one word.
package bpos_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL  = 8'h0B;
  localparam logic [7:0] IDX_PIR     = 8'h0C;
  localparam logic [7:0] IDX_TMR     = 8'h11;
  localparam logic [7:0] IDX_TIMCTL  = 8'h12;
  localparam logic [7:0] IDX_DUTY    = 8'h15;
  localparam logic [7:0] IDX_ACTDUTY = 8'h16;
  localparam logic [7:0] IDX_CTL     = 8'h17;
  localparam logic [7:0] IDX_TRIS    = 8'h86;
  localparam logic [7:0] IDX_PIE     = 8'h8C;
  localparam logic [7:0] IDX_PR      = 8'h92;
  localparam logic [7:0] IDX_DBAND   = 8'h97;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TRIS = 8'hFF;
  localparam logic [7:0] RST_PR   = 8'hFF;

  // Field positions of the control registers
  localparam int CTL_DIR     = 7;
  localparam int CTL_FULL    = 6;
  localparam int CTL_DCLO_HI = 5;
  localparam int CTL_PWM_HI  = 3;
  localparam int CTL_POL_AC  = 1;
  localparam int CTL_POL_BD  = 0;
  localparam int T2_POST_HI  = 6;
  localparam int T2_RUN      = 2;
  localparam int PIR_PERIOD  = 1;
  localparam int TRIS_A      = 3;
  localparam int TRIS_B      = 5;
  localparam int TRIS_C      = 6;
  localparam int TRIS_D      = 7;

  // Oscillator cycles per instruction cycle, less one
  localparam logic [1:0] IC_LAST = 2'h3;
  // Last oscillator phase of one timer step for prescale 1, 4, 16
  localparam logic [5:0] PH_LAST_1  = 6'h03;
  localparam logic [5:0] PH_LAST_4  = 6'h0F;
  localparam logic [5:0] PH_LAST_16 = 6'h3F;
  // First phase of the early direction switch (1, 4, 16 oscillator periods)
  localparam logic [5:0] PH_LEAD_1  = 6'h03;
  localparam logic [5:0] PH_LEAD_4  = 6'h0C;
  localparam logic [5:0] PH_LEAD_16 = 6'h30;

  // Output configurations
  typedef enum logic [1:0] {
    BPOS_SINGLE,
    BPOS_HALF,
    BPOS_FULL_FWD,
    BPOS_FULL_REV
  } bpos_mode_t;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } bpos_wb_req_t;

  // Bridge pins: levels and enables, bit 0 = A .. bit 3 = D
  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] lvl;
  } bpos_pins_t;

endpackage

// ---- testbench/bpos_bridge_pwm_checker.sv ----
// Port-level assertions for the bridge PWM output stage.
// Assumes bind to the top module; mirrors register writes seen on the bus.
`timescale 1ns/1ps
module bpos_bridge_pwm_checker (
  // Clock and reset
  input wire logic                   clock_in,
  input wire logic                   rstn_in,
  // Bus and pins as seen at the top module
  input wire bpos_pkg::bpos_wb_req_t wb_req_in,
  input wire logic [31:0]            wb_dat_out,
  input wire logic                   wb_ack_out,
  input wire bpos_pkg::bpos_pins_t   bridge_pins_out,
  input wire logic                   period_timer_flag_out
);
  logic [7:0]  ctl;
  logic [7:0]  tris;
  logic [7:0]  dband;
  logic        run;
  logic [11:0] age;

  // Write decode and active levels after polarity
  wire [7:0] idx     = wb_req_in.adr[9:2];
  wire       wr      = wb_ack_out && wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && wb_req_in.sel[0];
  wire [3:0] act     = bridge_pins_out.lvl ^ {ctl[0], ctl[1], ctl[0], ctl[1]};
  wire       touch   = wr && (idx == 8'h17 || idx == 8'h97 || idx == 8'h92 || idx == 8'h12);
  wire       settled = run && (age == 12'hFFF);
  wire       on      = settled && (ctl[3:2] == 2'h3);

  // Shadow copies and age since the last setup write
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl   <= 8'h00;
      tris  <= 8'hFF;
      dband <= 8'h00;
      run   <= 1'b0;
      age   <= 12'h000;
    end else begin
      if (wr && idx == 8'h17) ctl <= wb_req_in.dat[7:0];
      if (wr && idx == 8'h86) tris <= wb_req_in.dat[7:0];
      if (wr && idx == 8'h97) dband <= wb_req_in.dat[7:0];
      if (wr && idx == 8'h12) run <= wb_req_in.dat[2];
      age <= touch ? 12'h000 : age + {11'h000, age != 12'hFFF};
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  a_ack_one_cycle: assert property (wb_req_in.cyc && wb_req_in.stb && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero while idle");
  a_oe_value: assert property (wr && idx == 8'h86 |-> ##3 bridge_pins_out.oe == ~{tris[7], tris[6], tris[5], tris[3]})
    else $error("pin enables do not follow direction bits");
  a_fwd_roles: assert property (on && ctl[7:6] == 2'h1 |-> act[0] && !act[1] && !act[2])
    else $error("forward roles wrong");
  a_rev_roles: assert property (on && ctl[7:6] == 2'h3 |-> act[2] && !act[0] && !act[3])
    else $error("reverse roles wrong");
  a_half_exclusive: assert property (on && ctl[7:6] == 2'h2 |-> !(act[0] && act[1]))
    else $error("half bridge outputs both active");
  a_disabled_low: assert property (settled && ctl[3:2] != 2'h3 |-> bridge_pins_out.lvl == 4'h0)
    else $error("pins driven while pwm disabled");
  a_band_on_rise: assert property (on && ctl[7:6] == 2'h2 && dband >= 8'h02 && $rose(act[0]) |-> $past(act[1], 4) == 1'b0)
    else $error("dead band too short before A");
  a_zero_band: assert property (on && ctl[7:6] == 2'h2 && dband == 8'h00 && $fell(act[0]) |-> $rose(act[1]))
    else $error("zero dead band edges apart");

  c_fwd: cover property (on && ctl[7:6] == 2'h1);
  c_rev: cover property (on && ctl[7:6] == 2'h3);
  c_band: cover property (on && ctl[7:6] == 2'h2 && dband == 8'h02);
endmodule

// ---- testbench/bpos_fet_driver_model.sv ----
// Model of the external FET drivers on the four bridge pins.
// Assumes a bias resistor holds each released pin at its switch-off level.
`timescale 1ns/1ps
module bpos_fet_driver_model (
  // Pins and chosen polarity
  input  wire bpos_pkg::bpos_pins_t pins_in,
  input  wire logic [1:0]           pol_in,
  // Switch states
  output logic [3:0]                switch_on_out,
  output logic                      shoot_out
);
  // Off level per pin, bit 0 = A
  wire [3:0] off_lvl = {pol_in[0], pol_in[1], pol_in[0], pol_in[1]};
  // Released pins fall to the off level
  wire [3:0] pad = (pins_in.oe & pins_in.lvl) | (~pins_in.oe & off_lvl);
  // Switch conducts on the active level; A/B and C/D share a leg
  assign switch_on_out = pad ^ off_lvl;
  assign shoot_out     = (switch_on_out[0] & switch_on_out[1]) | (switch_on_out[2] & switch_on_out[3]);
endmodule

// ---- testbench/test_bpos_bridge_pwm.sv ----
// Self-checking bench for the bridge PWM output stage.
// Assumes the checker and driver model files are compiled first.
`timescale 1ns/1ps
module test_bpos_bridge_pwm;
  typedef struct {
    logic [7:0] ctl;
    logic [9:0] duty;
    int         exp_on [4];
  } bpos_row_t;

  logic                   clock_in   = 1'b0;
  logic                   rstn_in    = 1'b0;
  bpos_pkg::bpos_wb_req_t req        = '0;
  logic [1:0]             pol        = 2'h0;
  logic [31:0]            rdat;
  logic                   ack;
  logic                   flag;
  logic                   shoot;
  logic [3:0]             on;
  bpos_pkg::bpos_pins_t   pins;
  logic [7:0]             q;
  int                     fail_count = 0;
  int                     compares   = 0;
  int                     cycles     = 0;
  logic [31:0]            cnt [5];
  int                     n;
  logic [31:0]            d;
  int                     lead [3]   = '{1, 4, 16};
  logic [15:0]            rst_tab [5] = '{16'h86FF, 16'h92FF, 16'h1700, 16'h9700, 16'h1100};
  // Period 32 clocks: ctl, duty, active clocks of A..D (-1 ignored)
  bpos_row_t rows [7] = '{
    '{8'h0C, 10'd10, '{10, -1, -1, -1}},
    '{8'h8F, 10'd12, '{12, 20, -1, -1}},
    '{8'h4D, 10'd20, '{32, 0, 0, 20}},
    '{8'hCE, 10'd5,  '{0, 5, 32, 0}},
    '{8'h0C, 10'd0,  '{0, -1, -1, -1}},
    '{8'h0C, 10'd40, '{32, -1, -1, -1}},
    '{8'h00, 10'd10, '{0, 0, 0, 0}}
  };

  // Clock
  always #5 clock_in = ~clock_in;

  bpos_bridge_pwm u_dut (
    .clock_in              (clock_in),
    .rstn_in               (rstn_in),
    .wb_req_in             (req),
    .wb_dat_out            (rdat),
    .wb_ack_out            (ack),
    .bridge_pins_out       (pins),
    .period_timer_flag_out (flag)
  );

  bpos_fet_driver_model u_fet (
    .pins_in       (pins),
    .pol_in        (pol),
    .switch_on_out (on),
    .shoot_out     (shoot)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One classic cycle; waits for ack with no bound, expects it after two clocks
  task automatic xfer(input logic [7:0] idx, input logic we, input logic [7:0] dat);
    int k;
    k = 0;
    @(posedge clock_in);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: {2'h0, idx, 2'h0}, dat: {24'h0, dat}};
    do begin
      @(posedge clock_in);
      k++;
    end while (ack !== 1'b1);
    check("bus ack wait", k, 2);
    q = rdat[7:0];
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    xfer(idx, 1'b1, dat);
  endtask

  task automatic rd(input logic [7:0] idx);
    xfer(idx, 1'b0, 8'h00);
  endtask

  task automatic mode(input logic [7:0] ctl, input logic [9:0] duty);
    wr(8'h15, duty[9:2]);
    pol <= ctl[1:0];
    wr(8'h17, {ctl[7:6], duty[1:0], ctl[3:0]});
  endtask

  task automatic measure(input int len);
    cnt = '{default: 0};
    repeat (len) begin
      @(negedge clock_in);
      for (int i = 0; i < 4; i++) cnt[i] += on[i];
      cnt[4] += shoot;
    end
  endtask

  task automatic wait_flag();
    int k;
    k = 0;
    while (flag !== 1'b1 && k < 2000) begin
      @(posedge clock_in);
      k++;
    end
    check("period flag", flag, 1'b1);
  endtask

  task automatic done(input string t);
    $display("test %s done", t);
  endtask

  // Hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    // Bring-up with pins still inputs
    wr(8'h92, 8'h07);
    mode(8'h0C, 10'd10);
    wr(8'h97, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h12, 8'h04);
    wait_flag();
    check("oe before enable", pins.oe, 4'h0);
    wr(8'h86, 8'h17);
    repeat (3) @(posedge clock_in);
    check("oe after enable", pins.oe, 4'hF);
    done("setup");
    // Mode table: pins released while the mode and polarity change
    foreach (rows[r]) begin
      wr(8'h86, 8'hFF);
      mode(rows[r].ctl, rows[r].duty);
      repeat (4200) @(posedge clock_in);
      wr(8'h86, 8'h17);
      repeat (4) @(posedge clock_in);
      measure(32);
      for (int i = 0; i < 4; i++) begin
        if (rows[r].exp_on[i] >= 0) check("active clocks", cnt[i], rows[r].exp_on[i]);
      end
      check("shoot", cnt[4], 0);
    end
    done("mode table");
    // Half bridge with two instruction cycles of dead band
    wr(8'h97, 8'h02);
    mode(8'h8C, 10'd16);
    repeat (4200) @(posedge clock_in);
    measure(32);
    check("band a", cnt[0] inside {[8:11]}, 1);
    check("band b", cnt[1] inside {[8:11]}, 1);
    check("band shoot", cnt[4], 0);
    wr(8'h97, 8'h00);
    done("dead band");
    // Forward to reverse at each prescale
    for (int p = 0; p < 3; p++) begin
      wr(8'h12, 8'h04 | p[7:0]);
      mode(8'h4C, 10'd40);
      repeat (2100) @(posedge clock_in);
      // Reverse at full duty just after a restart; ideal drivers turn off at once
      wr(8'h0C, 8'h00);
      repeat (2) @(posedge clock_in);
      wait_flag();
      mode(8'hCC, 10'd40);
      n = 0;
      while (on[2] !== 1'b1 && n < 2000) begin
        @(negedge clock_in);
        n++;
      end
      check("a released", on[0], 1'b0);
      n = 0;
      d = 0;
      while (on[1] !== 1'b1 && n < 100) begin
        d += on[3];
        @(negedge clock_in);
        n++;
      end
      check("lead clocks", n, lead[p]);
      check("modulated idle", d, 0);
    end
    wr(8'h12, 8'h04);
    done("direction");
    // Flag clear aligned just after a period start
    mode(8'h0C, 10'd10);
    repeat (200) @(posedge clock_in);
    while (on[0] !== 1'b0) @(negedge clock_in);
    while (on[0] !== 1'b1) @(negedge clock_in);
    wr(8'h0C, 8'h00);
    repeat (2) @(posedge clock_in);
    check("flag cleared", flag, 1'b0);
    wait_flag();
    rd(8'h0C);
    check("flag bit", q[1], 1'b1);
    done("flag");
    // Duty latch, read-only and unmapped places
    rd(8'h16);
    check("active duty", q, 8'h02);
    wr(8'h16, 8'h55);
    rd(8'h16);
    check("read only", q, 8'h02);
    rd(8'h40);
    check("unmapped", q, 8'h00);
    done("bus");
    // Second reset in mid-run
    @(posedge clock_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    check("pins in reset", pins, 8'h00);
    check("flag in reset", flag, 1'b0);
    rstn_in <= 1'b1;
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][15:8]);
      check("reset value", q, rst_tab[i][7:0]);
    end
    done("reset");
    summarize();
  end
endmodule

bind bpos_bridge_pwm bpos_bridge_pwm_checker u_chk (
  .clock_in              (clock_in),
  .rstn_in               (rstn_in),
  .wb_req_in             (wb_req_in),
  .wb_dat_out            (wb_dat_out),
  .wb_ack_out            (wb_ack_out),
  .bridge_pins_out       (bridge_pins_out),
  .period_timer_flag_out (period_timer_flag_out)
);
